// ---- include/card_link_cfg.svh ----
`ifndef CARD_LINK_CFG_SVH
`define CARD_LINK_CFG_SVH

// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_FI          8'h04
`define OFS_WI          8'h08
`define OFS_TXDATA      8'h0C
`define OFS_RXDATA      8'h10
`define OFS_STATUS      8'h14
`define OFS_HEADER      8'h18

// status bit positions
`define STS_RX_VALID    0
`define STS_TX_PEND     1
`define STS_BUSY        2
`define STS_HDR_DONE    3
`define STS_PAR_ERR     4
`define STS_TX_FAIL     5
`define STS_WWT_OVER    6
`define STS_RX_OVR      7

// reset values
`define FI_RESET        12'h174
`define WI_RESET        8'h0A
`define DI_LOG_RESET    3'h0

// frame timing in half-etu steps from the start edge
`define PH_START_CHK    5'h01
`define PH_PARITY_RX    5'h13
`define PH_RX_CHECK     5'h14
`define PH_ERR_ON       5'h15
`define PH_ERR_OFF      5'h18
`define PH_PARITY_TX    5'h12
`define PH_TX_RELEASE   5'h14
`define PH_TX_CHECK     5'h16
`define PH_TX_DONE      5'h18
`define PH_RETRY        5'h1A
`define MIN_GAP         5'h18

// waiting time, header, procedure bytes
`define WWT_MULT        30'h3C0
`define NULL_BYTE       8'h60
`define HDR_OPC_POS     3'h1
`define HDR_LAST        3'h4

`endif

// ---- include/card_link_pkg.sv ----
package card_link_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RX   = 3'b010,
		ST_TX   = 3'b100
	} link_state_t;

	typedef struct packed {
		logic [2:0] di_log;
		logic       clk_stop_ok;
		logic       auto_null;
		logic       proto_on;
		logic       inverse;
	} ctrl_t;

	typedef struct packed {
		link_state_t st;
		logic [4:0]  phase;
		logic [11:0] hcnt;
		logic [4:0]  gap;
		logic [29:0] work_wait_time;
		logic [8:0]  shreg;
		logic [8:0]  txbits;
		logic [2:0]  tries;
		logic        frame_bad;
		ctrl_t       ctrl;
		logic [11:0] fi;
		logic [7:0]  wi;
		logic [7:0]  txbuf;
		logic        tx_pend;
		logic [7:0]  rxbuf;
		logic        rx_valid;
		logic        rx_ovr;
		logic        hdr_done;
		logic [2:0]  hdr_cnt;
		logic [7:0]  opcode;
		logic        par_err;
		logic        tx_fail;
		logic        wwt_over;
		logic        io_prev;
		logic        oe;
		logic        io_lvl;
		logic [31:0] rdata;
	} state_t;

endpackage

// ---- rtl/card_char_link.sv ----
// Implementation choices: strobed register access and the address map.
`timescale 1ns/100ps
`include "card_link_cfg.svh"
// How it works
// - beyond class A forces clock-stop indication on
// - card always signals parity errors, repeats characters
// - card implements the character protocol
// - command tracking only after reset answer done
// - line must be high before a start
// - convention sets which line level is one
// - frame is start, eight data, parity
// - even parity over data and parity bit
// - confirm start mid-bit, sample at half etu
// - transmit bit edges on whole etu boundaries
// - line released high during guard time
// - bit order within byte follows convention
// - starts spaced at least twelve etu apart
// - card start within work waiting time
// - card answers complete header with procedure byte
// - error pulse low from 10.5 etu, 1.5 etu
// - error seen at 11 etu triggers resend later
module card_char_link
	import card_link_pkg::*;
#(
	parameter int unsigned MAX_REPEAT     = 4,
	parameter bit          BEYOND_CLASS_A = 1'b1
) (
	// clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	// card I/O line, open drain
	input  wire logic        i_io,
	output logic             o_io_out,
	output logic             o_io_oe,
	// register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [31:0]      o_rdata
);

	generate
		if (MAX_REPEAT < 1 || MAX_REPEAT > 7) begin : g_bad_repeat
			$error("MAX_REPEAT must lie in 1..7");
		end
	endgenerate

	state_t      s_r;
	state_t      s_nxt;
	logic [11:0] etu_cyc;
	logic [11:0] half_m1;
	logic        tick;
	logic [4:0]  ph_n;
	logic [29:0] wwt_limit;
	logic        fall;
	logic [7:0]  rx_byte;
	logic        rx_bad;
	logic        rx_deliver;
	logic [8:0]  tx_frame;

	// line order of a byte; its own inverse, so it serves both directions
	function automatic logic [7:0] line_conv(input logic [7:0] b, input logic inv);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = b[7 - i];
		end
		return inv ? ~r : b;
	endfunction

	function automatic state_t begin_tx(input state_t s, input logic [8:0] frame);
		state_t t;
		t           = s;
		t.st        = ST_TX;
		t.phase     = 5'h00;
		t.hcnt      = 12'h000;
		t.oe        = 1'b1;
		t.txbits    = frame;
		t.frame_bad = 1'b0;
		t.gap       = 5'h00;
		t.work_wait_time       = 30'h0;
		return t;
	endfunction

	// only power-of-two baud factors are served, so no divider is needed
	assign etu_cyc    = s_r.fi >> s_r.ctrl.di_log;
	assign half_m1    = (etu_cyc[11:1] <= 11'h001) ? 12'h000 : {1'b0, etu_cyc[11:1]} - 12'h001;
	assign tick       = (s_r.hcnt == half_m1);
	assign ph_n       = (s_r.phase == 5'h1F) ? 5'h1F : s_r.phase + 5'h01;
	assign wwt_limit  = `WWT_MULT * {22'h0, s_r.wi} * {18'h0, s_r.fi};
	assign fall       = s_r.io_prev & ~i_io;
	assign rx_byte    = line_conv(s_r.shreg[7:0], s_r.ctrl.inverse);
	assign rx_bad     = (^s_r.shreg) ^ s_r.ctrl.inverse;
	assign rx_deliver = (s_r.st == ST_RX) && tick && (ph_n == `PH_RX_CHECK) && !rx_bad;
	assign tx_frame   = {(^s_r.txbuf) ^ s_r.ctrl.inverse, line_conv(s_r.txbuf, s_r.ctrl.inverse)};

	always_comb begin
		s_nxt         = s_r;
		s_nxt.io_prev = i_io;
		s_nxt.rdata   = 32'h0;
		s_nxt.hcnt    = tick ? 12'h000 : s_r.hcnt + 12'h001;
		if (tick && s_r.gap != 5'h1F) begin
			s_nxt.gap = s_r.gap + 5'h01;
		end
		if (s_r.work_wait_time != 30'h3FFFFFFF) begin
			s_nxt.work_wait_time = s_r.work_wait_time + 30'h1;
		end

		if (i_wr) begin
			case (i_addr)
				`OFS_CTRL: begin
					s_nxt.ctrl             = ctrl_t'(i_wdata[6:0]);
					s_nxt.ctrl.clk_stop_ok = i_wdata[3] | BEYOND_CLASS_A;
				end
				`OFS_FI: s_nxt.fi = i_wdata[11:0];
				`OFS_WI: s_nxt.wi = i_wdata[7:0];
				`OFS_TXDATA: begin
					// a byte under transmission must survive for repeats
					if (!s_r.tx_pend) begin
						s_nxt.txbuf   = i_wdata[7:0];
						s_nxt.tx_pend = 1'b1;
					end
				end
				`OFS_STATUS: begin
					if (i_wdata[`STS_HDR_DONE]) begin
						s_nxt.hdr_done = 1'b0;
						s_nxt.hdr_cnt  = 3'h0;
					end
					if (i_wdata[`STS_PAR_ERR]) begin
						s_nxt.par_err = 1'b0;
					end
					if (i_wdata[`STS_TX_FAIL]) begin
						s_nxt.tx_fail = 1'b0;
					end
					if (i_wdata[`STS_WWT_OVER]) begin
						s_nxt.wwt_over = 1'b0;
					end
					if (i_wdata[`STS_RX_OVR]) begin
						s_nxt.rx_ovr = 1'b0;
					end
				end
				default: ;
			endcase
		end

		if (i_rd) begin
			case (i_addr)
				`OFS_CTRL:   s_nxt.rdata = {25'h0, s_r.ctrl};
				`OFS_FI:     s_nxt.rdata = {20'h0, s_r.fi};
				`OFS_WI:     s_nxt.rdata = {24'h0, s_r.wi};
				`OFS_TXDATA: s_nxt.rdata = {24'h0, s_r.txbuf};
				`OFS_RXDATA: begin
					s_nxt.rdata    = {24'h0, s_r.rxbuf};
					s_nxt.rx_valid = 1'b0;
				end
				`OFS_STATUS: s_nxt.rdata = {24'h0, s_r.rx_ovr, s_r.wwt_over, s_r.tx_fail,
					s_r.par_err, s_r.hdr_done, s_r.st != ST_IDLE, s_r.tx_pend, s_r.rx_valid};
				`OFS_HEADER: s_nxt.rdata = {21'h0, s_r.hdr_cnt, s_r.opcode};
				default:     s_nxt.rdata = 32'h0;
			endcase
		end

		// a null byte at half the waiting time keeps the terminal waiting
		if (s_r.ctrl.auto_null && s_r.hdr_done && !s_nxt.tx_pend && s_r.st == ST_IDLE
			&& s_r.work_wait_time >= (wwt_limit >> 1)) begin
			s_nxt.txbuf   = `NULL_BYTE;
			s_nxt.tx_pend = 1'b1;
		end
		if (s_r.hdr_done && s_r.st == ST_IDLE && s_r.work_wait_time == wwt_limit) begin
			s_nxt.wwt_over = 1'b1;
		end

		// one engine for both directions: the line is half duplex
		unique case (s_r.st)
			ST_IDLE: begin
				if (fall) begin
					s_nxt.st        = ST_RX;
					s_nxt.phase     = 5'h00;
					s_nxt.hcnt      = 12'h000;
					s_nxt.frame_bad = 1'b0;
					s_nxt.gap       = 5'h00;
					s_nxt.work_wait_time       = 30'h0;
				end else if (s_r.tx_pend && s_r.io_prev && i_io
					&& s_r.gap >= `MIN_GAP) begin
					s_nxt = begin_tx(s_nxt, tx_frame);
				end
			end
			ST_RX: begin
				if (tick) begin
					s_nxt.phase = ph_n;
					if (ph_n == `PH_START_CHK && i_io) begin
						s_nxt.st = ST_IDLE;
					end else if (ph_n[0] && ph_n >= 5'h03 && ph_n <= `PH_PARITY_RX) begin
						s_nxt.shreg = {i_io, s_r.shreg[8:1]};
					end
					if (ph_n == `PH_RX_CHECK) begin
						if (rx_bad) begin
							s_nxt.frame_bad = 1'b1;
							s_nxt.par_err   = 1'b1;
						end else begin
							s_nxt.st    = ST_IDLE;
							s_nxt.rxbuf = rx_byte;
							if (s_nxt.rx_valid) begin
								s_nxt.rx_ovr = 1'b1;
							end
							s_nxt.rx_valid = 1'b1;
							if (s_r.ctrl.proto_on && !s_r.hdr_done) begin
								if (s_r.hdr_cnt == `HDR_OPC_POS) begin
									s_nxt.opcode = rx_byte;
								end
								if (s_r.hdr_cnt == `HDR_LAST) begin
									s_nxt.hdr_done = 1'b1;
									s_nxt.hdr_cnt  = 3'h0;
								end else begin
									s_nxt.hdr_cnt = s_r.hdr_cnt + 3'h1;
								end
							end
						end
					end
					if (ph_n == `PH_ERR_ON && s_r.frame_bad) begin
						s_nxt.oe = 1'b1;
					end
					if (ph_n == `PH_ERR_OFF) begin
						s_nxt.oe = 1'b0;
						s_nxt.st = ST_IDLE;
					end
				end
			end
			ST_TX: begin
				if (tick) begin
					s_nxt.phase = ph_n;
					if (!ph_n[0] && ph_n >= 5'h02 && ph_n <= `PH_PARITY_TX) begin
						s_nxt.oe     = ~s_r.txbits[0];
						s_nxt.txbits = {1'b0, s_r.txbits[8:1]};
					end
					if (ph_n == `PH_TX_RELEASE) begin
						s_nxt.oe = 1'b0;
					end
					if (ph_n == `PH_TX_CHECK && !i_io) begin
						s_nxt.frame_bad = 1'b1;
					end
					if (ph_n == `PH_TX_DONE && !s_r.frame_bad) begin
						s_nxt.st      = ST_IDLE;
						s_nxt.tx_pend = 1'b0;
						s_nxt.tries   = 3'h0;
					end
					// resend waits for the terminal to release the line
					if (ph_n >= `PH_RETRY && s_r.frame_bad && i_io) begin
						if (s_r.tries == 3'(MAX_REPEAT)) begin
							s_nxt.st      = ST_IDLE;
							s_nxt.tx_pend = 1'b0;
							s_nxt.tries   = 3'h0;
							s_nxt.tx_fail = 1'b1;
						end else begin
							s_nxt       = begin_tx(s_nxt, tx_frame);
							s_nxt.tries = s_r.tries + 3'h1;
						end
					end
				end
			end
			default: s_nxt.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			s_r                  <= '0;
			s_r.st               <= ST_IDLE;
			s_r.fi               <= `FI_RESET;
			s_r.wi               <= `WI_RESET;
			s_r.ctrl.di_log      <= `DI_LOG_RESET;
			s_r.ctrl.clk_stop_ok <= BEYOND_CLASS_A;
			s_r.io_prev          <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_io_out = s_r.io_lvl;
	assign o_io_oe  = s_r.oe;
	assign o_rdata  = s_r.rdata;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);

	chk_start_line_high: assert property ($rose(s_r.st == ST_TX) |->
		$past(i_io) && $past(s_r.io_prev)) else $error("start while line low");
	chk_start_spacing: assert property ($rose(s_r.st == ST_TX) |->
		$past(s_r.gap) >= `MIN_GAP) else $error("starts closer than 12 etu");
	chk_start_bit_low: assert property ((s_r.st == ST_TX && s_r.phase < 5'h02) |-> s_r.oe)
		else $error("start bit not low");
	chk_guard_released: assert property ((s_r.st == ST_TX && s_r.phase >= `PH_TX_RELEASE)
		|-> !s_r.oe) else $error("line held in guard time");
	chk_tx_parity_even: assert property ((s_r.st == ST_TX && tick && ph_n == `PH_PARITY_TX)
		|=> s_r.oe == ~((^s_r.txbuf) ^ s_r.ctrl.inverse)) else $error("bad parity");
	chk_err_pulse_window: assert property ((s_r.st == ST_RX && s_r.oe) |->
		(s_r.phase >= `PH_ERR_ON && s_r.phase < `PH_ERR_OFF))
		else $error("error pulse out of window");
	chk_err_after_bad: assert property ((s_r.st == ST_RX && tick && ph_n == `PH_ERR_ON
		&& s_r.frame_bad) |=> s_r.oe [*1] ##1 s_r.oe) else $error("no error pulse");
	chk_resend_count: assert property ((s_r.st == ST_TX && s_r.frame_bad && tick
		&& ph_n >= `PH_RETRY && i_io && s_r.tries < 3'(MAX_REPEAT)) |=>
		(s_r.tries == $past(s_r.tries) + 3'h1 && s_r.phase == 5'h00 && s_r.oe))
		else $error("resend not started");
	chk_header_done: assert property ((rx_deliver && s_r.ctrl.proto_on && !s_r.hdr_done
		&& s_r.hdr_cnt == `HDR_LAST) |=> s_r.hdr_done && s_r.hdr_cnt == 3'h0)
		else $error("header end missed");

	cov_rx_char: cover property (rx_deliver);
	cov_resend: cover property (s_r.st == ST_TX && s_r.tries != 3'h0 && s_r.phase == 5'h00);
	cov_tx_fail: cover property ($rose(s_r.tx_fail));
	cov_header: cover property ($rose(s_r.hdr_done));

endmodule // card_char_link

// ---- testbench/term_model.sv ----
`timescale 1ns/100ps
module term_model (
	input  wire logic clk,
	input  wire logic inv,
	input  wire logic card_oe,
	output logic      line
);
	logic        t_oe = 1'b0;
	int unsigned cyc  = 0;
	int unsigned ts   = 0;
	// pull-up: a released line reads high, never a stale level
	assign line = ~(card_oe | t_oe);
	always @(posedge clk) begin
		cyc <= cyc + 1;
	end
	function automatic logic lb(input logic [7:0] b, input int i);
		return (i == 8) ? ^b : (inv ? b[7 - i] : b[i]);
	endfunction
	// one etu is 16 cycles here; the bench sets the clock factor to match
	task automatic send(input logic [7:0] b, input logic bad, output logic err, output logic rel);
		@(posedge clk);
		ts = cyc;
		t_oe <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			repeat (16) @(posedge clk);
			t_oe <= (lb(b, i) ^ (bad && i == 8)) ~^ inv;
		end
		repeat (16) @(posedge clk);
		t_oe <= 1'b0;
		repeat (16) @(posedge clk);
		err = ~line;
		repeat (32) @(posedge clk);
		rel = line;
		// next start no sooner than 14 etu after this one
		repeat (16) @(posedge clk);
	endtask
	task automatic recv(input logic nack, output logic [7:0] b, output logic pok,
			output int unsigned t0);
		logic [8:0] s;
		int         n;
		// a nack of the previous call is still on the line until this edge
		@(posedge clk);
		n = 0;
		while (line !== 1'b0 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		t0 = cyc;
		for (int k = 0; k < 9; k++) begin
			repeat (k == 0 ? 24 : 16) @(posedge clk);
			s[k] = line ^ inv;
		end
		for (int i = 0; i < 8; i++) begin
			b[inv ? 7 - i : i] = s[i];
		end
		pok = ~^s;
		repeat (16) @(posedge clk);
		t_oe <= nack;
		repeat (24) @(posedge clk);
		t_oe <= 1'b0;
	endtask
endmodule // term_model

// ---- testbench/card_char_link_tb.sv ----
`timescale 1ns/100ps
`include "card_link_cfg.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module card_char_link_tb;
	import card_link_pkg::*;
	logic        i_core_clk   = 1'b0;
	logic        i_rst_n      = 1'b0;
	logic [7:0]  i_addr       = 8'h00;
	logic [31:0] i_wdata      = 32'h0;
	logic        i_wr         = 1'b0;
	logic        i_rd         = 1'b0;
	logic        inv          = 1'b0;
	wire         line;
	logic        o_io_out;
	logic        o_io_oe;
	logic [31:0] o_rdata;
	logic [31:0] seed         = 32'h46;
	int unsigned errors       = 0;
	int unsigned total_checks = 0;
	int unsigned cycles       = 0;

	card_char_link dut_u (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_io       (line),
		.o_io_out   (o_io_out),
		.o_io_oe    (o_io_oe),
		.i_addr     (i_addr),
		.i_wdata    (i_wdata),
		.i_wr       (i_wr),
		.i_rd       (i_rd),
		.o_rdata    (o_rdata)
	);
	term_model term_u (.clk(i_core_clk), .inv(inv), .card_oe(o_io_oe), .line(line));

	always #25 i_core_clk = ~i_core_clk; // never stopped, so clock-stop timing holds

	function automatic logic [7:0] rnd8();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	function automatic logic [31:0] hdr_exp(input logic [2:0] n, input logic [7:0] op);
		return {21'h0, n, op};
	endfunction
	task automatic tally_and_finish();
		if (errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_core_clk);
		i_wr    <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] d;
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_core_clk);
		i_rd   <= 1'b0;
		#1 d = o_rdata;
		`CHK(nm, e, d)
	endtask

	// a few tens of characters of about 224 cycles plus one full waiting time of 15360
	always @(posedge i_core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			errors++;
			tally_and_finish();
		end
	end

	initial begin
		logic [7:0]  b;
		logic [7:0]  opc;
		logic [7:0]  got;
		logic        f1;
		logic        f2;
		int unsigned t1;
		int unsigned t2;
		repeat (4) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		rchk(`OFS_CTRL, 32'h8, "ctrl");
		rchk(`OFS_FI, 32'h174, "fi");
		rchk(`OFS_WI, 32'h0A, "wi");
		rchk(8'h1C, 32'h0, "unmapped");
		wr(`OFS_FI, 32'h10);
		term_u.send(8'h3C, 1'b0, f1, f2); // good reset answer stand-in, no re-reset
		rchk(`OFS_HEADER, 32'h0, "hdr before proto");
		wr(`OFS_CTRL, 32'h2);
		rchk(`OFS_CTRL, 32'hA, "ctrl rw");
		for (int i = 0; i < 5; i++) begin
			b = (i == 0) ? 8'hFF : rnd8();
			if (i == 1)
				opc = b;
			term_u.send(b, 1'b0, f1, f2);
			`CHK("no error pulse", 1'b0, f1)
			rchk(`OFS_RXDATA, {24'h0, b}, "rx byte");
		end
		// the count returns to zero once the fifth byte completes the header
		rchk(`OFS_HEADER, hdr_exp(3'h0, opc), "header");
		// the first byte was never read, so the next one overran it
		rchk(`OFS_STATUS, 32'h88, "hdr done");
		// short waiting time so the null byte comes out quickly
		wr(`OFS_WI, 32'h1);
		wr(`OFS_CTRL, 32'h6);
		term_u.recv(1'b0, got, f1, t1);
		`CHK("null byte", 8'h60, got)
		`CHK("null parity", 1'b1, f1)
		`CHK("wait bound", 1'b1, (t1 - term_u.ts) <= 32'h3C00)
		// with the null byte off the overrun flag waits for the full 15360 cycles
		wr(`OFS_CTRL, 32'h2);
		repeat (14700) @(posedge i_core_clk);
		rchk(`OFS_STATUS, 32'h88, "no early overrun");
		repeat (700) @(posedge i_core_clk);
		rchk(`OFS_STATUS, 32'hC8, "waiting overrun");
		wr(`OFS_STATUS, 32'hF8);
		term_u.send(rnd8(), 1'b1, f1, f2);
		`CHK("error pulse", 1'b1, f1)
		`CHK("pulse ended", 1'b1, f2)
		rchk(`OFS_STATUS, 32'h10, "parity error");
		wr(`OFS_STATUS, 32'hF8);
		for (int c = 0; c < 2; c++) begin
			inv <= c[0];
			wr(`OFS_CTRL, {31'h0, c[0]} | 32'h2);
			b = (c == 0) ? 8'h01 : rnd8();
			wr(`OFS_TXDATA, {24'h0, b});
			term_u.recv(1'b1, got, f1, t1);
			`CHK("tx byte", b, got)
			`CHK("tx parity", 1'b1, f1)
			term_u.recv(1'b0, got, f2, t2);
			`CHK("resend byte", b, got)
			`CHK("resend gap", 1'b1, (t2 - t1) >= 32'hD0)
			rchk(`OFS_STATUS, 32'h0, "tx done");
		end
		// inverse convention on the receive side as well
		b = rnd8();
		term_u.send(b, 1'b0, f1, f2);
		`CHK("inverse no pulse", 1'b0, f1)
		rchk(`OFS_RXDATA, {24'h0, b}, "inverse rx");
		// every attempt refused: after four resends the byte is dropped
		b = rnd8();
		wr(`OFS_TXDATA, {24'h0, b});
		for (int r = 0; r < 5; r++) begin
			term_u.recv(1'b1, got, f1, t1);
			`CHK("repeated byte", b, got)
		end
		repeat (20) @(posedge i_core_clk);
		rchk(`OFS_STATUS, 32'h20, "tx given up");
		`CHK("open drain level", 1'b0, o_io_out)
		tally_and_finish();
	end
endmodule // card_char_link_tb
